// [core/fmsp_defs.svh]
// Register offsets, field positions and timing counts of the serial port.
`ifndef FMSP_DEFS_SVH
`define FMSP_DEFS_SVH
`define FMSP_OFF_CTRL   5'h00
`define FMSP_OFF_DATA   5'h04
`define FMSP_OFF_BAUD   5'h08
`define FMSP_OFF_T1RLD  5'h0C
`define FMSP_OFF_T2RLD  5'h10
`define FMSP_C_MODE_HI  7
`define FMSP_C_MODE_LO  6
`define FMSP_C_MPF      5
`define FMSP_C_REN      4
`define FMSP_C_TB8      3
`define FMSP_C_RB8      2
`define FMSP_C_TI       1
`define FMSP_C_RI       0
`define FMSP_B_BAUD_DOUBLER     0
`define FMSP_B_T1M      1
`define FMSP_B_T1EXT    2
`define FMSP_B_TX_CLK_TIMER2_SEL     3
`define FMSP_B_RCLK     4
`define FMSP_B_T2EXT    5
`define FMSP_MODE_SYNC  2'h0
`define FMSP_MODE_8BIT  2'h1
`define FMSP_MODE_FIX   2'h2
`define FMSP_DIV12_LAST 4'hB
`define FMSP_DIV4_LAST  2'h3
`define FMSP_M0_RISE    4'h6
`define FMSP_M0_LASTBIT 4'h7
`define FMSP_TICK_LAST  4'hF
`define FMSP_RX_MID     4'h7
`define FMSP_STOP_IDX8  4'h9
`define FMSP_STOP_IDX9  4'hA
`define FMSP_RXLAST8    4'h8
`define FMSP_RXLAST9    4'h9
`define FMSP_T1_TOP     8'hFF
`define FMSP_T2_TOP     16'hFFFF
`endif

// [core/fmsp_pkg.sv]
// Types of the serial port: state machine states and the state record.
package fmsp_pkg;
   typedef enum logic [1:0] {M0_IDLE, M0_TX, M0_RX, M0_RDONE} fmsp_m0_e;
   typedef enum logic       {TX_IDLE, TX_RUN} fmsp_tx_e;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} fmsp_rx_e;

   typedef struct packed {
      logic [1:0]  mode;
      logic        mpf;
      logic        ren;
      logic        tb8;
      logic        rb8;
      logic        ti;
      logic        ri;
      logic        baud_doubler;
      logic        t1m;
      logic        t1ext;
      logic        tx_clk_timer2_sel;
      logic        rclk;
      logic        t2ext;
      logic [7:0]  t1rld;
      logic [7:0]  t1cnt;
      logic        t1half;
      logic [15:0] t2rld;
      logic [15:0] t2cnt;
      logic [3:0]  div12;
      logic [1:0]  div4;
      logic        t1pin_d;
      logic        t2pin_d;
      logic        rxd_d;
      logic        pend_wr;
      logic        pend_rd;
      logic        rd_wait;
      logic [4:0]  paddr;
      logic [31:0] hrdata;
      fmsp_m0_e    m0;
      logic [3:0]  m0cnt;
      logic [3:0]  m0bit;
      logic [7:0]  m0sh;
      fmsp_tx_e    tx;
      logic [10:0] txsh;
      logic [3:0]  txbit;
      logic [3:0]  txtick;
      fmsp_rx_e    rx;
      logic [9:0]  rxsh;
      logic [3:0]  rxbit;
      logic [3:0]  rxtick;
      logic [7:0]  rbuf;
      logic        txd;
      logic        rxoe;
   } fmsp_state_s;
endpackage : fmsp_pkg

// [core/fmsp_top.sv]
// Four-mode serial port with an AHB-Lite register slave and baud timers.
`timescale 1ns/100ps
`default_nettype none
`include "fmsp_defs.svh"

// Function
// - Received byte kept in separate holding register.
// - One data address: read receive, write transmit.
// - Set done flags on transmit and receive completion.
// - Done flags cleared only by software writes.
// - Mode bits choose sync, 8-bit, 9-bit modes.
// - Mode 0 half duplex, we drive clock.
// - Mode 0 write shifts eight bits LSB first.
// - Mode 0 receive when enabled, flag clear.
// - Mode 0 clock system_clock/12, receive pin open-drain.
// - Mode 1 frame: start, eight data, stop.
// - Async transmit done at start of stop.
// - Mode 1 accept rules with filter on stop.
// - Timer overflows set variable rate, per direction.
// - Timer 1 overflow divided by 32 or 16.
// - Timer 2 overflow divided by sixteen.
// - Timer 1 rate from selectable clock, reload.
// - Timer 2 counts system_clock/2 or pin falls, 16-bit reload.
// - Timer 2 select bits force baud generator.
// - Mode 2 frame carries programmable ninth bit.
// - Mode 2 accept rules with filter on ninth.
// - Mode 2 rate system_clock/64 or system_clock/32.
// - Mode 3 is mode 2 with timer rate.
module fmsp_top (
   input  wire logic        CLK_SYS,
   input  wire logic        SRST,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic             HREADYOUT,
   output logic             HRESP,
   output logic [31:0]      HRDATA,
   output logic             TXD_O,
   input  wire logic        RXD_I,
   output logic             RXD_O,
   output logic             RXD_OE,
   input  wire logic        T1_CLK_IN,
   input  wire logic        T2_CLK_IN
);
   fmsp_pkg::fmsp_state_s s_ff;
   fmsp_pkg::fmsp_state_s nxt_s;

   logic        div12_p;
   logic        sys2_p;
   logic        sys4_p;
   logic        t1_en;
   logic        t1_ovf;
   logic        t2_en;
   logic        t2_ovf;
   logic        t1_x16;
   logic        fix_x16;
   logic        tx_tick;
   logic        rx_tick;
   logic        acc;
   logic        wr_ctrl;
   logic        tx_start;
   logic        rx_fin;
   logic        rx_flag;
   logic [3:0]  tx_stop;
   logic [3:0]  rx_last;
   logic [31:0] rdv;

   // HSIZE is not decoded; only whole-word transfers are expected.
   assign HRESP  = 1'b0;
   assign HRDATA = s_ff.hrdata;
   assign TXD_O  = s_ff.txd;
   // The receive pin only ever pulls low; a pull-up makes the high level.
   assign RXD_O  = 1'b0;
   assign RXD_OE = s_ff.rxoe;
   assign HREADYOUT = ~(s_ff.pend_rd & ~s_ff.rd_wait);

   always_comb begin
      nxt_s = s_ff;
      rdv   = '0;

      // Prescalers shared by the timers and the fixed-rate mode.
      div12_p = (s_ff.div12 == `FMSP_DIV12_LAST);
      nxt_s.div12 = div12_p ? '0 : s_ff.div12 + 4'h1;
      nxt_s.div4  = s_ff.div4 + 2'h1;
      sys2_p = s_ff.div4[0];
      sys4_p = (s_ff.div4 == `FMSP_DIV4_LAST);
      nxt_s.t1pin_d = T1_CLK_IN;
      nxt_s.t2pin_d = T2_CLK_IN;
      nxt_s.rxd_d   = RXD_I;

      // Timer 1: 8-bit auto-reload counter.
      if (s_ff.t1ext) begin
         t1_en = s_ff.t1pin_d & ~T1_CLK_IN;
      end else begin
         t1_en = s_ff.t1m | div12_p;
      end
      t1_ovf = t1_en && (s_ff.t1cnt == `FMSP_T1_TOP);
      if (t1_ovf) begin
         nxt_s.t1cnt  = s_ff.t1rld;
         nxt_s.t1half = ~s_ff.t1half;
      end else if (t1_en) begin
         nxt_s.t1cnt = s_ff.t1cnt + 8'h01;
      end

      // Timer 2 runs only while a direction has picked it; parked, it holds
      // its reload so the first bit after selection has full length.
      if (s_ff.t2ext) begin
         t2_en = (s_ff.tx_clk_timer2_sel | s_ff.rclk) & s_ff.t2pin_d & ~T2_CLK_IN;
      end else begin
         t2_en = (s_ff.tx_clk_timer2_sel | s_ff.rclk) & sys2_p;
      end
      t2_ovf = t2_en && (s_ff.t2cnt == `FMSP_T2_TOP);
      if (t2_ovf || !(s_ff.tx_clk_timer2_sel | s_ff.rclk)) begin
         nxt_s.t2cnt = s_ff.t2rld;
      end else if (t2_en) begin
         nxt_s.t2cnt = s_ff.t2cnt + 16'h0001;
      end

      // Sixteen ticks per bit: halving timer 1 gives the divide by 32.
      t1_x16  = t1_ovf & (s_ff.baud_doubler | s_ff.t1half);
      fix_x16 = s_ff.baud_doubler ? sys2_p : sys4_p;
      if (s_ff.mode == `FMSP_MODE_FIX) begin
         tx_tick = fix_x16;
         rx_tick = fix_x16;
      end else begin
         tx_tick = s_ff.tx_clk_timer2_sel ? t2_ovf : t1_x16;
         rx_tick = s_ff.rclk ? t2_ovf : t1_x16;
      end

      // Bus slave: writes take effect in the data phase without waits,
      // reads insert one wait state so the data comes from a flop.
      acc = HSEL & HTRANS[1] & HREADY;
      unique case (s_ff.paddr)
         `FMSP_OFF_CTRL: begin
            rdv[`FMSP_C_MODE_HI:`FMSP_C_MODE_LO] = s_ff.mode;
            rdv[`FMSP_C_MPF] = s_ff.mpf;
            rdv[`FMSP_C_REN] = s_ff.ren;
            rdv[`FMSP_C_TB8] = s_ff.tb8;
            rdv[`FMSP_C_RB8] = s_ff.rb8;
            rdv[`FMSP_C_TI]  = s_ff.ti;
            rdv[`FMSP_C_RI]  = s_ff.ri;
         end
         `FMSP_OFF_DATA: begin
            rdv[7:0] = s_ff.rbuf;
         end
         `FMSP_OFF_BAUD: begin
            rdv[`FMSP_B_BAUD_DOUBLER]  = s_ff.baud_doubler;
            rdv[`FMSP_B_T1M]   = s_ff.t1m;
            rdv[`FMSP_B_T1EXT] = s_ff.t1ext;
            rdv[`FMSP_B_TX_CLK_TIMER2_SEL]  = s_ff.tx_clk_timer2_sel;
            rdv[`FMSP_B_RCLK]  = s_ff.rclk;
            rdv[`FMSP_B_T2EXT] = s_ff.t2ext;
         end
         `FMSP_OFF_T1RLD: rdv[7:0]  = s_ff.t1rld;
         `FMSP_OFF_T2RLD: rdv[15:0] = s_ff.t2rld;
         default:         rdv = '0;
      endcase
      if (s_ff.pend_rd && !s_ff.rd_wait) begin
         nxt_s.rd_wait = 1'b1;
         nxt_s.hrdata  = rdv;
      end else begin
         nxt_s.rd_wait = 1'b0;
         nxt_s.pend_wr = acc & HWRITE;
         nxt_s.pend_rd = acc & ~HWRITE;
         if (acc) begin
            nxt_s.paddr = HADDR[4:0];
         end
      end

      wr_ctrl  = s_ff.pend_wr && (s_ff.paddr == `FMSP_OFF_CTRL);
      tx_start = s_ff.pend_wr && (s_ff.paddr == `FMSP_OFF_DATA);
      if (wr_ctrl) begin
         nxt_s.mode = HWDATA[`FMSP_C_MODE_HI:`FMSP_C_MODE_LO];
         nxt_s.mpf  = HWDATA[`FMSP_C_MPF];
         nxt_s.ren  = HWDATA[`FMSP_C_REN];
         nxt_s.tb8  = HWDATA[`FMSP_C_TB8];
         nxt_s.rb8  = HWDATA[`FMSP_C_RB8];
         nxt_s.ti   = HWDATA[`FMSP_C_TI];
         nxt_s.ri   = HWDATA[`FMSP_C_RI];
      end
      if (s_ff.pend_wr && (s_ff.paddr == `FMSP_OFF_BAUD)) begin
         nxt_s.baud_doubler  = HWDATA[`FMSP_B_BAUD_DOUBLER];
         nxt_s.t1m   = HWDATA[`FMSP_B_T1M];
         nxt_s.t1ext = HWDATA[`FMSP_B_T1EXT];
         nxt_s.tx_clk_timer2_sel  = HWDATA[`FMSP_B_TX_CLK_TIMER2_SEL];
         nxt_s.rclk  = HWDATA[`FMSP_B_RCLK];
         nxt_s.t2ext = HWDATA[`FMSP_B_T2EXT];
      end
      if (s_ff.pend_wr && (s_ff.paddr == `FMSP_OFF_T1RLD)) begin
         nxt_s.t1rld = HWDATA[7:0];
      end
      if (s_ff.pend_wr && (s_ff.paddr == `FMSP_OFF_T2RLD)) begin
         nxt_s.t2rld = HWDATA[15:0];
      end

      // Mode 0 engine: one shared shifter, so the mode is half duplex.
      unique case (s_ff.m0)
         fmsp_pkg::M0_IDLE: begin
            nxt_s.m0cnt = '0;
            nxt_s.m0bit = '0;
            if (s_ff.mode == `FMSP_MODE_SYNC) begin
               if (tx_start) begin
                  nxt_s.m0   = fmsp_pkg::M0_TX;
                  nxt_s.m0sh = HWDATA[7:0];
               end else if (s_ff.ren && !s_ff.ri) begin
                  nxt_s.m0 = fmsp_pkg::M0_RX;
               end
            end
         end
         fmsp_pkg::M0_TX, fmsp_pkg::M0_RX: begin
            nxt_s.m0cnt = s_ff.m0cnt + 4'h1;
            if ((s_ff.m0 == fmsp_pkg::M0_RX) &&
                (s_ff.m0cnt == `FMSP_M0_RISE)) begin
               nxt_s.m0sh = {RXD_I, s_ff.m0sh[7:1]};
               if (s_ff.m0bit == `FMSP_M0_LASTBIT) begin
                  nxt_s.m0 = fmsp_pkg::M0_RDONE;
               end
            end
            if (s_ff.m0cnt == `FMSP_DIV12_LAST) begin
               nxt_s.m0cnt = '0;
               nxt_s.m0bit = s_ff.m0bit + 4'h1;
               nxt_s.m0sh  = (s_ff.m0 == fmsp_pkg::M0_TX) ?
                             {1'b0, s_ff.m0sh[7:1]} : s_ff.m0sh;
               if (s_ff.m0bit == `FMSP_M0_LASTBIT) begin
                  nxt_s.m0 = fmsp_pkg::M0_IDLE;
                  nxt_s.ti = 1'b1;
               end
            end
         end
         fmsp_pkg::M0_RDONE: begin
            nxt_s.m0   = fmsp_pkg::M0_IDLE;
            nxt_s.rbuf = s_ff.m0sh;
            nxt_s.ri   = 1'b1;
         end
         default: nxt_s.m0 = fmsp_pkg::M0_IDLE;
      endcase

      // Asynchronous transmitter; a write while busy is dropped.
      tx_stop = (s_ff.mode == `FMSP_MODE_8BIT) ? `FMSP_STOP_IDX8
                                               : `FMSP_STOP_IDX9;
      unique case (s_ff.tx)
         fmsp_pkg::TX_IDLE: begin
            if (tx_start && (s_ff.mode != `FMSP_MODE_SYNC)) begin
               nxt_s.tx     = fmsp_pkg::TX_RUN;
               nxt_s.txbit  = '0;
               nxt_s.txtick = '0;
               nxt_s.txsh   = {1'b1,
                               (s_ff.mode == `FMSP_MODE_8BIT) | s_ff.tb8,
                               HWDATA[7:0], 1'b0};
            end
         end
         fmsp_pkg::TX_RUN: begin
            if (tx_tick) begin
               nxt_s.txtick = s_ff.txtick + 4'h1;
               if (s_ff.txtick == `FMSP_TICK_LAST) begin
                  nxt_s.txsh  = {1'b1, s_ff.txsh[10:1]};
                  nxt_s.txbit = s_ff.txbit + 4'h1;
                  if (s_ff.txbit == tx_stop - 4'h1) begin
                     nxt_s.ti = 1'b1;
                  end
                  if (s_ff.txbit == tx_stop) begin
                     nxt_s.tx = fmsp_pkg::TX_IDLE;
                  end
               end
            end
         end
         default: nxt_s.tx = fmsp_pkg::TX_IDLE;
      endcase

      // Asynchronous receiver.
      rx_last = (s_ff.mode == `FMSP_MODE_8BIT) ? `FMSP_RXLAST8
                                               : `FMSP_RXLAST9;
      rx_fin  = 1'b0;
      // The stop bit is the filter bit in mode 1, the ninth otherwise.
      rx_flag = (s_ff.mode == `FMSP_MODE_8BIT) ? RXD_I : s_ff.rxsh[8];
      unique case (s_ff.rx)
         fmsp_pkg::RX_IDLE: begin
            if (s_ff.ren && (s_ff.mode != `FMSP_MODE_SYNC) &&
                s_ff.rxd_d && !RXD_I) begin
               nxt_s.rx     = fmsp_pkg::RX_START;
               nxt_s.rxtick = '0;
            end
         end
         fmsp_pkg::RX_START: begin
            if (rx_tick) begin
               nxt_s.rxtick = s_ff.rxtick + 4'h1;
               if (s_ff.rxtick == `FMSP_RX_MID) begin
                  nxt_s.rxtick = '0;
                  nxt_s.rxbit  = '0;
                  nxt_s.rx = RXD_I ? fmsp_pkg::RX_IDLE
                                   : fmsp_pkg::RX_BITS;
               end
            end
         end
         fmsp_pkg::RX_BITS: begin
            if (rx_tick) begin
               nxt_s.rxtick = s_ff.rxtick + 4'h1;
               if (s_ff.rxtick == `FMSP_TICK_LAST) begin
                  nxt_s.rxsh[s_ff.rxbit] = RXD_I;
                  nxt_s.rxbit = s_ff.rxbit + 4'h1;
                  if (s_ff.rxbit == rx_last) begin
                     nxt_s.rx = fmsp_pkg::RX_IDLE;
                     rx_fin   = 1'b1;
                  end
               end
            end
         end
         default: nxt_s.rx = fmsp_pkg::RX_IDLE;
      endcase
      // A frame that fails the test leaves buffer and flags untouched.
      if (rx_fin && !s_ff.ri && (!s_ff.mpf || rx_flag)) begin
         nxt_s.rbuf = s_ff.rxsh[7:0];
         nxt_s.rb8  = rx_flag;
         nxt_s.ri   = 1'b1;
      end

      // Pins follow the next state so they line up with it once stored.
      if ((nxt_s.m0 == fmsp_pkg::M0_TX) || (nxt_s.m0 == fmsp_pkg::M0_RX))
      begin
         nxt_s.txd = (nxt_s.m0cnt >= `FMSP_M0_RISE);
      end else if (nxt_s.tx == fmsp_pkg::TX_RUN) begin
         nxt_s.txd = nxt_s.txsh[0];
      end else begin
         nxt_s.txd = 1'b1;
      end
      nxt_s.rxoe = (nxt_s.m0 == fmsp_pkg::M0_TX) & ~nxt_s.m0sh[0];
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         s_ff       <= '0;
         s_ff.txd   <= 1'b1;
         s_ff.rxd_d <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SRST);

   sequence m0_tx_begin;
      $rose(s_ff.m0 == fmsp_pkg::M0_TX);
   endsequence
   sequence m0_tx_end;
      (s_ff.m0 == fmsp_pkg::M0_IDLE) && s_ff.ti;
   endsequence

   a_ti_sticky: assert property (
      s_ff.ti && !wr_ctrl |=> s_ff.ti)
      else $error("transmit flag dropped without a write");
   a_ri_sticky: assert property (
      s_ff.ri && !wr_ctrl |=> s_ff.ri)
      else $error("receive flag dropped without a write");
   a_read_wait: assert property (
      s_ff.pend_rd && !s_ff.rd_wait |-> !HREADYOUT ##1 HREADYOUT)
      else $error("read wait state wrong");
   a_m0_byte_time: assert property (
      m0_tx_begin |-> ##96 m0_tx_end)
      else $error("mode 0 byte not done in 96 cycles");
   a_m0_shift_clk: assert property (
      (s_ff.m0 == fmsp_pkg::M0_TX) || (s_ff.m0 == fmsp_pkg::M0_RX)
      |-> TXD_O == (s_ff.m0cnt >= `FMSP_M0_RISE))
      else $error("mode 0 shift clock phase wrong");
   a_m0_rx_start: assert property (
      s_ff.m0 == fmsp_pkg::M0_IDLE && s_ff.mode == `FMSP_MODE_SYNC &&
      s_ff.ren && !s_ff.ri && !tx_start |=> s_ff.m0 == fmsp_pkg::M0_RX)
      else $error("mode 0 receive did not start");
   a_m0_rx_done: assert property (
      s_ff.m0 == fmsp_pkg::M0_RDONE
      |=> s_ff.ri && s_ff.rbuf == $past(s_ff.m0sh))
      else $error("mode 0 receive not completed");
   a_rx_refused: assert property (
      rx_fin && s_ff.ri |=> $stable(s_ff.rbuf) && $stable(s_ff.rb8))
      else $error("frame taken while receive flag set");
   a_rx_accept: assert property (
      rx_fin && !s_ff.ri && (!s_ff.mpf || rx_flag)
      |=> s_ff.ri && s_ff.rbuf == $past(s_ff.rxsh[7:0]))
      else $error("valid frame not stored");
   a_tx_start_bit: assert property (
      $rose(s_ff.tx == fmsp_pkg::TX_RUN) |-> !TXD_O)
      else $error("start bit missing");
   a_ti_at_stop: assert property (
      s_ff.tx == fmsp_pkg::TX_RUN && $changed(s_ff.txbit) &&
      s_ff.txbit == tx_stop |-> s_ff.ti && TXD_O)
      else $error("transmit flag not set at stop bit");
   a_t1_reload: assert property (
      t1_ovf |=> s_ff.t1cnt == $past(s_ff.t1rld))
      else $error("timer 1 reload wrong");
   a_t2_parked: assert property (
      !s_ff.tx_clk_timer2_sel && !s_ff.rclk |=> s_ff.t2cnt == $past(s_ff.t2rld))
      else $error("timer 2 ran while unselected");
endmodule : fmsp_top
`default_nettype wire

// [sim/fmsp_remote.sv]
// Remote serial device model: asynchronous frames and mode 0 slave.
`timescale 1ns/100ps
`default_nettype none
module fmsp_remote (
   input  wire logic clk,
   input  wire logic txd,
   input  wire logic line,
   output logic      drv
);
   // The line has a pull-up, so a released line reads high.
   initial drv = 1'b1;

   // Drives start, data, ninth and stop bits LSB first.
   task automatic send(input logic [10:0] v, input int n, input int per);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         drv <= v[i];
         repeat (per - 1) @(posedge clk);
      end
   endtask : send

   // Samples bit centres; the first bit may be short, so centres are
   // reckoned from the falling edge and tolerate one tick of error.
   task automatic capture(input int n, input int per,
                          output logic [10:0] v);
      v = 11'h000;
      @(negedge txd);
      repeat (per / 2) @(negedge clk);
      for (int i = 0; i < n; i++) begin
         if (i > 0) begin
            repeat (per) @(negedge clk);
         end
         v[i] = txd;
      end
   endtask : capture

   task automatic m0_capture(output logic [7:0] v, output realtime per);
      realtime t0;
      t0 = 0;
      for (int i = 0; i < 8; i++) begin
         @(posedge txd);
         v[i] = line;
         if (i == 1) begin
            per = $realtime - t0;
         end
         t0 = $realtime;
      end
   endtask : m0_capture

   // Slave presents each bit after the shift clock falls.
   task automatic m0_send(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         @(negedge txd);
         drv <= v[i];
      end
      // The last bit is taken a cycle after the clock rises; hold it.
      @(posedge txd);
      repeat (6) @(posedge clk);
      drv <= 1'b1;
   endtask : m0_send
endmodule : fmsp_remote
`default_nettype wire

// [sim/tb.sv]
// Testbench of the serial port: bus tasks and serial scenarios.
`timescale 1ns/100ps
`default_nettype none
`include "fmsp_defs.svh"
module tb;
   logic        clk_sys = 1'b0;
   logic        srst    = 1'b1;
   logic        hsel    = 1'b0;
   logic [31:0] haddr   = 32'h0;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'b0;
   logic [31:0] hwdata  = 32'h0;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        txd_o;
   logic        rxd_o;
   logic        rxd_oe;
   logic        rem_drv;
   logic        rx_line;
   logic        hresp;
   logic [1:0]  tpin    = 2'h0;
   int          miscompares = 0;
   int          compares    = 0;

   always #5 clk_sys = ~clk_sys;

   // Timer pins fall once every four cycles, slower than system_clock/2 but faster than system_clock/12.
   always @(posedge clk_sys) tpin <= tpin + 2'h1;

   // The open-drain pull from the port wins over the remote drive.
   assign rx_line = rxd_oe ? rxd_o : rem_drv;

   fmsp_top dut_u (
      .CLK_SYS  (clk_sys),
      .SRST     (srst),
      .HSEL     (hsel),
      .HADDR    (haddr),
      .HTRANS   (htrans),
      .HWRITE   (hwrite),
      .HSIZE    (3'h2),
      .HWDATA   (hwdata),
      .HREADY   (hreadyout),
      .HREADYOUT(hreadyout),
      .HRESP    (hresp),
      .HRDATA   (hrdata),
      .TXD_O    (txd_o),
      .RXD_I    (rx_line),
      .RXD_O    (rxd_o),
      .RXD_OE   (rxd_oe),
      .T1_CLK_IN(tpin[1]),
      .T2_CLK_IN(tpin[1])
   );

   fmsp_remote rem_u (
      .clk (clk_sys),
      .txd (txd_o),
      .line(rx_line),
      .drv (rem_drv)
   );

   task automatic report_and_stop;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Ready is looked at before each rising edge, so the edge that ends
   // a phase is the one at which it was seen high.
   task automatic xfer(input logic w, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_sys);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {27'h000_0000, a};
      for (int p = 0; p < 2; p++) begin
         do @(negedge clk_sys); while (hreadyout !== 1'b1);
         r = hrdata;
         @(posedge clk_sys);
         hsel   <= 1'b0;
         htrans <= 2'h0;
         hwdata <= d;
      end
   endtask : xfer

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask : wr

   task automatic rdc(input logic [4:0] a, input logic [31:0] e,
                      input string nm);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk(nm, e, r);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : rdc

   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      report_and_stop();
   end

   initial begin
      logic [10:0] v;
      realtime     per;
      int          n;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      rdc(`FMSP_OFF_CTRL, 32'h0, "ctrl reset");
      rdc(`FMSP_OFF_BAUD, 32'h0, "baud reset");
      wr(5'h14, 32'h0000_00FF);
      rdc(5'h14, 32'h0, "unmapped");
      for (int s = 0; s < 2; s++) begin
         wr(`FMSP_OFF_BAUD, 32'(s));
         wr(`FMSP_OFF_CTRL, 32'h0000_0088);
         fork
            rem_u.capture(11, 64 >> s, v);
            wr(`FMSP_OFF_DATA, 32'h0000_00A5);
         join
         chk("mode 2 frame", 32'h0000_074A, {21'h0, v});
         rdc(`FMSP_OFF_CTRL, 32'h0000_008A, "tx done");
         // Let the stop bit end, or the next write finds the sender busy.
         repeat (64) @(posedge clk_sys);
      end
      // Receive and transmit overlap to show full duplex.
      wr(`FMSP_OFF_T1RLD, 32'h0000_00FE);
      wr(`FMSP_OFF_BAUD, 32'h0000_0003);
      // Timer 1 may sit far below its reload; wait out one full lap.
      repeat (260) @(posedge clk_sys);
      wr(`FMSP_OFF_CTRL, 32'h0000_0050);
      fork
         rem_u.send(11'h278, 10, 32);
         rem_u.capture(10, 32, v);
         wr(`FMSP_OFF_DATA, 32'h0000_0096);
      join
      chk("mode 1 frame", 32'h0000_032C, {21'h0, v});
      rdc(`FMSP_OFF_CTRL, 32'h0000_0057, "mode 1 flags");
      rdc(`FMSP_OFF_DATA, 32'h0000_003C, "mode 1 byte");
      rem_u.send(11'h386, 10, 32);
      rdc(`FMSP_OFF_DATA, 32'h0000_003C, "held byte");
      rdc(`FMSP_OFF_CTRL, 32'h0000_0057, "flags kept");
      wr(`FMSP_OFF_T2RLD, 32'h0000_FFFE);
      wr(`FMSP_OFF_BAUD, 32'h0000_0018);
      wr(`FMSP_OFF_CTRL, 32'h0000_00F0);
      rem_u.send(11'h422, 11, 64);
      rdc(`FMSP_OFF_CTRL, 32'h0000_00F0, "filtered ctrl");
      rdc(`FMSP_OFF_DATA, 32'h0000_003C, "filtered byte");
      rem_u.send(11'h644, 11, 64);
      rdc(`FMSP_OFF_CTRL, 32'h0000_00F5, "mode 3 ctrl");
      rdc(`FMSP_OFF_DATA, 32'h0000_0022, "mode 3 byte");
      // Timer 1, then timer 2, counting falls of its pin.
      for (int s = 0; s < 2; s++) begin
         wr(`FMSP_OFF_BAUD, s ? 32'h0000_0028 : 32'h0000_0005);
         wr(`FMSP_OFF_CTRL, 32'h0000_0040);
         fork
            rem_u.capture(10, 128, v);
            wr(`FMSP_OFF_DATA, 32'h0000_005A);
         join
         chk("pin clocked frame", 32'h0000_02B4, {21'h0, v});
         repeat (128) @(posedge clk_sys);
      end
      wr(`FMSP_OFF_BAUD, 32'h0);
      wr(`FMSP_OFF_CTRL, 32'h0);
      fork
         rem_u.m0_capture(v[7:0], per);
         wr(`FMSP_OFF_DATA, 32'h0000_00B4);
      join
      chk("mode 0 data", 32'h0000_00B4, {24'h0, v[7:0]});
      chk("shift period", 32'h0000_0078, 32'(int'(per)));
      repeat (12) @(posedge clk_sys);
      rdc(`FMSP_OFF_CTRL, 32'h0000_0002, "mode 0 tx done");
      fork
         rem_u.m0_send(8'h6D);
         wr(`FMSP_OFF_CTRL, 32'h0000_0010);
      join
      repeat (12) @(posedge clk_sys);
      rdc(`FMSP_OFF_CTRL, 32'h0000_0011, "mode 0 rx done");
      rdc(`FMSP_OFF_DATA, 32'h0000_006D, "mode 0 byte");
      // With the flag still set no shift clock may appear.
      n = 0;
      repeat (40) begin
         @(negedge clk_sys);
         n += int'(txd_o !== 1'b1);
      end
      chk("halted clock", 32'h0, 32'(n));
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
